// ===== core/pcsd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcsd_defs.svh"

module pcsd_top
   import pcsd_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic       sample_tick,
   input  wire logic       input_a_raw,
   input  wire logic       input_b_raw,
   input  wire logic [1:0] counter_mode_sel,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   output logic [7:0]      sfr_rdata,
   output logic            input_a_filtered,
   output logic            input_b_filtered,
   output logic            direction,
   output logic            flutter
);

   // configuration registers

   logic [7:0]     debounce_high_count;  // high debounce setting
   logic [7:0]     debounce_low_count;   // low debounce setting
   pcsd_count_type high_limit;           // applied high threshold
   pcsd_count_type low_limit;            // applied low threshold
   logic           integ_bypass;         // integrators switched off
   logic           quad_mode;            // quadrature counting active

   // software writes to the debounce settings
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         debounce_high_count <= `PCSD_DCH_RESET;
         debounce_low_count  <= `PCSD_DCL_RESET;
      end else if (clk_en && sfr_wr) begin
         case (sfr_addr)
            `PCSD_ADDR_DCH: begin
               debounce_high_count <= sfr_wdata;
            end
            `PCSD_ADDR_DCL: begin
               debounce_low_count <= sfr_wdata;
            end
            default: begin
               // status and unmapped addresses ignore writes
            end
         endcase
      end
   end

   // thresholds, bypass and mode decode
   always_comb begin
      high_limit   = pcsd_limit(debounce_high_count);
      low_limit    = pcsd_limit(debounce_low_count);
      integ_bypass = (debounce_low_count == 8'h00);
      quad_mode    = (counter_mode_sel == `PCSD_MODE_QUAD);
   end

   // integrators, one per input

   logic level_a;  // integrator a output
   logic level_b;  // integrator b output

   pcsd_integrator u_integ_a (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .clk_en      (clk_en),
      .sample_tick (sample_tick),
      .raw_level   (input_a_raw),
      .high_limit  (high_limit),
      .low_limit   (low_limit),
      .bypass      (integ_bypass),
      .level       (level_a)
   );

   pcsd_integrator u_integ_b (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .clk_en      (clk_en),
      .sample_tick (sample_tick),
      .raw_level   (input_b_raw),
      .high_limit  (high_limit),
      .low_limit   (low_limit),
      .bypass      (integ_bypass),
      .level       (level_b)
   );

   // current and previous filtered levels

   logic input_a_prev_level;  // previous filtered a
   logic input_b_prev_level;  // previous filtered b
   logic level_change;        // an integrator output moved

   // integrator outputs sampled one clock later
   logic seen_a;              // last observed a
   logic seen_b;              // last observed b

   always_comb begin
      level_change = (level_a != seen_a) || (level_b != seen_b);
   end

   // keep the old pair when either output changes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seen_a             <= 1'b0;
         seen_b             <= 1'b0;
         input_a_prev_level <= 1'b0;
         input_b_prev_level <= 1'b0;
      end else if (clk_en) begin
         seen_a <= level_a;
         seen_b <= level_b;
         if (level_change) begin
            input_a_prev_level <= seen_a;
            input_b_prev_level <= seen_b;
         end
      end
   end

   // filtered levels straight from the integrator flops
   always_comb begin
      input_a_filtered = level_a;
      input_b_filtered = level_b;
   end

   // quadrature state machine and direction

   pcsd_state_type quad_state;       // present pair position
   pcsd_state_type next_quad_state;  // position of new pair
   logic           step_ccw;         // one step b-first order
   logic           step_cw;          // one step a-first order

   // pair letters read as (a, b): lh means a low, b high
   always_comb begin
      case ({level_a, level_b})
         2'b00:   next_quad_state = pcsd_st_ll;
         2'b01:   next_quad_state = pcsd_st_lh;
         2'b11:   next_quad_state = pcsd_st_hh;
         2'b10:   next_quad_state = pcsd_st_hl;
         default: next_quad_state = pcsd_st_ll;
      endcase
   end

   // classify the step from present to new position
   always_comb begin
      step_ccw = 1'b0;
      step_cw  = 1'b0;
      case (quad_state)
         pcsd_st_ll: begin
            step_ccw = (next_quad_state == pcsd_st_lh);
            step_cw  = (next_quad_state == pcsd_st_hl);
         end
         pcsd_st_lh: begin
            step_ccw = (next_quad_state == pcsd_st_hh);
            step_cw  = (next_quad_state == pcsd_st_ll);
         end
         pcsd_st_hh: begin
            step_ccw = (next_quad_state == pcsd_st_hl);
            step_cw  = (next_quad_state == pcsd_st_lh);
         end
         pcsd_st_hl: begin
            step_ccw = (next_quad_state == pcsd_st_ll);
            step_cw  = (next_quad_state == pcsd_st_hh);
         end
         default: begin
            step_ccw = 1'b0;
            step_cw  = 1'b0;
         end
      endcase
   end

   // state tracks the pair; direction follows legal steps in quadrature
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         quad_state <= pcsd_st_ll;
         direction  <= 1'b0;
      end else if (clk_en) begin
         quad_state <= next_quad_state;
         if (quad_mode) begin
            if (step_ccw) begin
               direction <= 1'b0;
            end else if (step_cw) begin
               direction <= 1'b1;
            end
         end
      end
   end

   // flutter detection

   // edges alternate between inputs in clean rotation; two
   // same-kind edges in a row from one input mean the counts differ
   logic rise_a;          // rising edge on a
   logic rise_b;          // rising edge on b
   logic fall_a;          // falling edge on a
   logic fall_b;          // falling edge on b
   logic rise_owner;      // input of last rising edge, 1 = b
   logic rise_seen;       // a rising edge has been recorded
   logic fall_owner;      // input of last falling edge, 1 = b
   logic fall_seen;       // a falling edge has been recorded
   logic rise_mismatch;   // rising edge counts now differ by one or two
   logic fall_mismatch;   // falling edge counts now differ by one or two

   always_comb begin
      rise_a = level_a && !seen_a;
      rise_b = level_b && !seen_b;
      fall_a = !level_a && seen_a;
      fall_b = !level_b && seen_b;
      rise_mismatch = rise_seen &&
                      ((rise_a && !rise_b && !rise_owner) ||
                       (rise_b && !rise_a && rise_owner));
      fall_mismatch = fall_seen &&
                      ((fall_a && !fall_b && !fall_owner) ||
                       (fall_b && !fall_a && fall_owner));
   end

   // edge bookkeeping and sticky flag, cleared outside quadrature
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rise_owner <= 1'b0;
         rise_seen  <= 1'b0;
         fall_owner <= 1'b0;
         fall_seen  <= 1'b0;
         flutter    <= 1'b0;
      end else if (clk_en) begin
         if (!quad_mode) begin
            rise_seen <= 1'b0;
            fall_seen <= 1'b0;
            flutter   <= 1'b0;
         end else begin
            if (rise_a ^ rise_b) begin
               rise_owner <= rise_b;
               rise_seen  <= 1'b1;
            end
            if (fall_a ^ fall_b) begin
               fall_owner <= fall_b;
               fall_seen  <= 1'b1;
            end
            if (rise_mismatch || fall_mismatch) begin
               flutter <= 1'b1;
            end
         end
      end
   end

   // register read port

   logic [7:0] counter_status;  // assembled status byte

   always_comb begin
      counter_status = 8'h00;
      counter_status[`PCSD_BIT_FLUTTER] = flutter;
      counter_status[`PCSD_BIT_DIR]     = direction;
      counter_status[`PCSD_BIT_STATE_HI:`PCSD_BIT_STATE_LO] =
         quad_state;
      counter_status[`PCSD_BIT_B_PREV]  = input_b_prev_level;
      counter_status[`PCSD_BIT_A_PREV]  = input_a_prev_level;
      counter_status[`PCSD_BIT_B_CUR]   = level_b;
      counter_status[`PCSD_BIT_A_CUR]   = level_a;
   end

   // read data registered one clock after the strobe
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en && sfr_rd) begin
         case (sfr_addr)
            `PCSD_ADDR_STATUS: sfr_rdata <= counter_status;
            `PCSD_ADDR_DCH:    sfr_rdata <= debounce_high_count;
            `PCSD_ADDR_DCL:    sfr_rdata <= debounce_low_count;
            default:           sfr_rdata <= 8'h00;
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== core/pcsd_defs.svh
`ifndef PCSD_DEFS_SVH
`define PCSD_DEFS_SVH

// register addresses on the special function bus
`define PCSD_ADDR_STATUS   8'hc1
`define PCSD_ADDR_DCL      8'hf9
`define PCSD_ADDR_DCH      8'hfa

// reset values of the debounce settings
`define PCSD_DCH_RESET     8'h04
`define PCSD_DCL_RESET     8'h04

// counter mode field value for quadrature counting
`define PCSD_MODE_QUAD     2'b11

// status register bit positions
`define PCSD_BIT_FLUTTER   7
`define PCSD_BIT_DIR       6
`define PCSD_BIT_STATE_HI  5
`define PCSD_BIT_STATE_LO  4
`define PCSD_BIT_B_PREV    3
`define PCSD_BIT_A_PREV    2
`define PCSD_BIT_B_CUR     1
`define PCSD_BIT_A_CUR     0

`endif

// ===== core/pcsd_pkg.sv
`default_nettype none

package pcsd_pkg;

   // position of the filtered input pair in the quadrature cycle
   typedef enum logic [1:0] {
      pcsd_st_ll,
      pcsd_st_lh,
      pcsd_st_hh,
      pcsd_st_hl
   } pcsd_state_type;

   // integrator count, one bit wider than a setting
   typedef logic [8:0] pcsd_count_type;

   // applied threshold is the programmed setting plus one
   function automatic pcsd_count_type pcsd_limit(input logic [7:0] setting);
      pcsd_limit = {1'b0, setting} + 9'h001;
   endfunction

endpackage
`default_nettype wire

// ===== core/pcsd_integrator.sv
`timescale 1ns/1ps
`default_nettype none

// up/down integrator for one sensor input
module pcsd_integrator
   import pcsd_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           sys_rst,
   input  wire logic           clk_en,
   input  wire logic           sample_tick,
   input  wire logic           raw_level,
   input  wire pcsd_count_type high_limit,
   input  wire pcsd_count_type low_limit,
   input  wire logic           bypass,
   output logic                level
);

   pcsd_count_type count;       // integration count
   pcsd_count_type next_count;  // count after this sample
   logic           next_level;  // level after this sample

   // count moves up on high samples, down on low samples
   always_comb begin
      next_count = count;
      next_level = level;
      if (bypass) begin
         // integrators off: level follows the sample
         next_level = raw_level;
         next_count = raw_level ? low_limit : '0;
      end else if (!level) begin
         // low side: climb toward the high threshold
         if (raw_level) begin
            next_count = count + 9'h001;
         end else if (count != '0) begin
            next_count = count - 9'h001;
         end
         if (raw_level && (next_count >= high_limit)) begin
            next_level = 1'b1;
            next_count = low_limit;
         end
      end else begin
         // high side: fall from the low threshold toward zero
         if (!raw_level) begin
            next_count = (count > low_limit) ? low_limit - 9'h001
                                             : count - 9'h001;
         end else if (count < low_limit) begin
            next_count = count + 9'h001;
         end
         if (next_count == '0) begin
            next_level = 1'b0;
         end
      end
   end

   // state advances once per sample tick
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count <= '0;
         level <= 1'b0;
      end else if (clk_en && sample_tick) begin
         count <= next_count;
         level <= next_level;
      end
   end

endmodule
`default_nettype wire

// ===== verif/pcsd_reed_pair.sv
`timescale 1ns/1ps
`default_nettype none

// two reed switches; switch a can chatter on command
module pcsd_reed_pair (
   input  wire logic ref_clk,
   input  wire logic want_a,
   input  wire logic want_b,
   input  wire logic chatter,
   output logic      raw_a,
   output logic      raw_b
);
   logic flip = 1'b0; // bounce phase

   // bounce phase moves just after the sampling edge, only while commanded
   always @(posedge ref_clk) begin
      flip <= chatter ? ~flip : 1'b0;
   end

   assign raw_a = want_a ^ flip;
   assign raw_b = want_b;
endmodule

`default_nettype wire

// ===== verif/pcsd_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

// port checker for the status and debounce block
module pcsd_top_properties (
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   input wire logic       clk_en,
   input wire logic       sample_tick,
   input wire logic       input_a_raw,
   input wire logic       input_b_raw,
   input wire logic [1:0] counter_mode_sel,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       input_a_filtered,
   input wire logic       input_b_filtered,
   input wire logic       direction,
   input wire logic       flutter
);
   logic [1:0] lv;    // filtered pair, b then a
   logic       rd_st; // status read taken
   logic       q;     // quadrature selected

   assign lv = {input_b_filtered, input_a_filtered};
   assign rd_st = clk_en && sfr_rd && sfr_addr == 8'hc1;
   assign q = counter_mode_sel == 2'b11;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // settled levels show in state and current bits
   property p_status;
      (clk_en && $stable(lv))[*2] ##1 (rd_st && $stable(lv)) |=>
         {sfr_rdata[5:4], sfr_rdata[1:0]} == {$past(lv[0]), $past(^lv), $past(lv)};
   endproperty
   a_status: assert property (p_status) else $error("status fields wrong");
   // high setting reads back what was written
   property p_dch_rw;
      clk_en && sfr_wr && sfr_addr == 8'hfa ##1 clk_en && sfr_rd && !sfr_wr && sfr_addr == 8'hfa
         |=> sfr_rdata == $past(sfr_wdata, 2);
   endproperty
   a_dch_rw: assert property (p_dch_rw) else $error("high setting lost");
   // a rise needs a taken high sample
   property p_rise_a;
      $rose(input_a_filtered) |-> $past(input_a_raw && sample_tick && clk_en);
   endproperty
   a_rise_a: assert property (p_rise_a) else $error("a rose without high sample");
   // a fall needs a taken low sample
   property p_fall_b;
      $fell(input_b_filtered) |-> $past(sys_rst) || $past(!input_b_raw && sample_tick && clk_en);
   endproperty
   a_fall_b: assert property (p_fall_b) else $error("b fell without low sample");
   // levels move only on taken ticks
   property p_hold;
      !(clk_en && sample_tick) |=> $stable(lv);
   endproperty
   a_hold: assert property (p_hold) else $error("level moved off tick");
   // flutter is sticky inside quadrature
   property p_flutter_keep;
      flutter && q ##1 q |-> flutter;
   endproperty
   a_flutter_keep: assert property (p_flutter_keep) else $error("flutter dropped");
   // no flutter outside quadrature
   property p_flutter_quad;
      (!q && clk_en)[*3] |-> !flutter;
   endproperty
   a_flutter_quad: assert property (p_flutter_quad) else $error("flutter off quad");
   // direction moves only in quadrature
   property p_dir_mode;
      $changed(direction) |-> $past(sys_rst) || $past(q) || $past(q, 2);
   endproperty
   a_dir_mode: assert property (p_dir_mode) else $error("direction off quad");

   c_flutter: cover property ($rose(flutter));
   c_cw: cover property ($rose(direction));
   c_ccw: cover property ($fell(direction));
endmodule

bind pcsd_top pcsd_top_properties u_props (.ref_clk, .sys_rst, .clk_en, .sample_tick,
   .input_a_raw, .input_b_raw, .counter_mode_sel, .sfr_addr, .sfr_wdata, .sfr_wr,
   .sfr_rd, .sfr_rdata, .input_a_filtered, .input_b_filtered, .direction, .flutter);

`default_nettype wire

// ===== verif/test_pulse_counter_status_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcsd_defs.svh"

// self-checking bench for the status and debounce block
module test_pulse_counter_status_debounce;
   typedef struct {logic wr; logic [7:0] addr; logic [7:0] data;} pcsd_row_type;

   logic       ref_clk, sys_rst, clk_en, sample_tick, want_a, want_b, chatter;
   logic       raw_a, raw_b, sfr_wr, sfr_rd, input_a_filtered, input_b_filtered;
   logic       direction, flutter;
   logic [1:0] counter_mode_sel;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   int         num_errors, cmp_count, cyc;
   // a samples and expected a levels, first tick in bit 0
   localparam logic [17:0] seq_a = 18'b111_00000_1111111_0_11;
   localparam logic [17:0] exp_a = 18'b1_000000_1111111_0000;
   // register cases: write, or read with expected value
   pcsd_row_type rows [0:10] = '{
      '{1'b0, `PCSD_ADDR_DCH, `PCSD_DCH_RESET}, '{1'b0, `PCSD_ADDR_DCL, `PCSD_DCL_RESET},
      '{1'b0, `PCSD_ADDR_STATUS, 8'h00}, '{1'b0, 8'h33, 8'h00},
      '{1'b1, `PCSD_ADDR_DCH, 8'ha5}, '{1'b0, `PCSD_ADDR_DCH, 8'ha5},
      '{1'b1, `PCSD_ADDR_STATUS, 8'hff}, '{1'b0, `PCSD_ADDR_STATUS, 8'h00},
      '{1'b1, `PCSD_ADDR_DCH, 8'h02}, '{1'b1, `PCSD_ADDR_DCL, 8'h01},
      '{1'b0, `PCSD_ADDR_DCL, 8'h01}};

   pcsd_reed_pair u_reeds (.ref_clk(ref_clk), .want_a(want_a), .want_b(want_b),
      .chatter(chatter), .raw_a(raw_a), .raw_b(raw_b));

   pcsd_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .sample_tick(sample_tick), .input_a_raw(raw_a), .input_b_raw(raw_b),
      .counter_mode_sel(counter_mode_sel), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .input_a_filtered(input_a_filtered), .input_b_filtered(input_b_filtered),
      .direction(direction), .flutter(flutter));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   // one write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask

   // settle, read one register, compare
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      repeat (3) @(negedge ref_clk);
      sfr_rd = 1'b1;
      sfr_addr = a;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      @(negedge ref_clk);
      chk(sfr_rdata, e);
   endtask

   // set both switches, then one sample tick
   task automatic tk(input logic a, input logic b);
      @(negedge ref_clk);
      want_a = a;
      want_b = b;
      sample_tick = 1'b1;
      @(negedge ref_clk);
      sample_tick = 1'b0;
   endtask

   // verdict and end of run
   task automatic results;
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      {sys_rst, clk_en} = 2'b11;
      {sample_tick, want_a, want_b, chatter, sfr_wr, sfr_rd} = 6'h00;
      {counter_mode_sel, sfr_addr, sfr_wdata} = 18'h00000;
      repeat (20) @(negedge ref_clk);
      sys_rst = 1'b0;
      // register table, ends with high 2 and low 1
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         else rd(rows[i].addr, rows[i].data);
      end
      // 3 highs to rise, 2 lows to fall, floor and cap hold
      for (int i = 0; i < 18; i++) begin
         tk(seq_a[i], 1'b0);
         chk(8'(input_a_filtered), 8'(exp_a[i]));
      end
      // chattering samples must not drop the level
      chatter = 1'b1;
      sample_tick = 1'b1;
      repeat (8) @(negedge ref_clk);
      {sample_tick, chatter} = 2'b00;
      chk(8'(input_a_filtered), 8'h01);
      // bypass, then quadrature steps
      wr(`PCSD_ADDR_DCL, 8'h00);
      tk(1'b0, 1'b0);
      chk(8'(input_a_filtered), 8'h00);
      counter_mode_sel = `PCSD_MODE_QUAD;
      tk(1'b1, 1'b0);
      tk(1'b1, 1'b1);
      rd(`PCSD_ADDR_STATUS, 8'h67);
      chk(8'(direction), 8'h01);
      tk(1'b0, 1'b1);
      tk(1'b0, 1'b0);
      // a reversal repeats an edge: restart the edge record outside quadrature
      counter_mode_sel = 2'b00;
      @(negedge ref_clk);
      counter_mode_sel = `PCSD_MODE_QUAD;
      tk(1'b0, 1'b1);
      tk(1'b1, 1'b1);
      rd(`PCSD_ADDR_STATUS, 8'h2b);
      chk(8'(direction), 8'h00);
      // a toggles alone: edge counts part
      repeat (2) begin
         tk(1'b0, 1'b1);
         tk(1'b1, 1'b1);
      end
      rd(`PCSD_ADDR_STATUS, 8'hab);
      chk(8'(flutter), 8'h01);
      // leave quadrature: direction holds
      counter_mode_sel = 2'b00;
      tk(1'b0, 1'b1);
      rd(`PCSD_ADDR_STATUS, 8'h1e);
      // write then read back to back, then reset again
      @(negedge ref_clk);
      {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, `PCSD_ADDR_DCH, 8'h5a};
      @(negedge ref_clk);
      {sfr_wr, sfr_rd} = 2'b01;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      @(negedge ref_clk);
      chk(sfr_rdata, 8'h5a);
      // clock enable low: tick and read are both ignored
      clk_en = 1'b0;
      tk(1'b1, 1'b0);
      {sfr_rd, sfr_addr} = {1'b1, `PCSD_ADDR_STATUS};
      @(negedge ref_clk);
      {sfr_rd, clk_en} = 2'b01;
      chk(8'(input_a_filtered), 8'h00);
      chk(8'(input_b_filtered), 8'h01);
      chk(sfr_rdata, 8'h5a);
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      rd(`PCSD_ADDR_DCH, `PCSD_DCH_RESET);
      rd(`PCSD_ADDR_STATUS, 8'h00);
      results();
   end
endmodule

`default_nettype wire
